// [logic/rmc_params.svh]
// offsets, field positions, reset values and fixed counts of the modem configuration bank
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH

`define RMC_ADDR_FEC_PRE_EXP 6'h13
`define RMC_ADDR_STEP_MANT 6'h14
`define RMC_ADDR_DEVIATION 6'h15
`define RMC_ADDR_RX_TIMEOUT 6'h16

`define RMC_RST_FEC_PRE_EXP 8'h22
`define RMC_RST_STEP_MANT 8'hF8
`define RMC_RST_DEVIATION 8'h47
`define RMC_RST_RX_TIMEOUT 8'h07

`define RMC_MASK_FEC_PRE_EXP 8'hF3
`define RMC_MASK_STEP_MANT 8'hFF
`define RMC_MASK_DEVIATION 8'h77
`define RMC_MASK_RX_TIMEOUT 8'h1F

`define RMC_BIT_FEC 7
`define RMC_PRE_HI 6
`define RMC_PRE_LO 4
`define RMC_SPC_E_HI 1
`define RMC_SPC_E_LO 0
`define RMC_DEV_E_HI 6
`define RMC_DEV_E_LO 4
`define RMC_DEV_M_HI 2
`define RMC_DEV_M_LO 0
`define RMC_BIT_EARLY_STOP 4
`define RMC_BIT_QUAL_GATE 3
`define RMC_RXT_HI 2
`define RMC_RXT_LO 0

`define RMC_STEP_OFFSET 12'h100
`define RMC_DEV_OFFSET 4'h8
`define RMC_EARLY_PERIODS 4'h8
`define RMC_RXT_UNLIMITED 3'h7

// rx timeout scale per wake resolution, code 0, fixed point with 8 fraction bits
`define RMC_RXT_K0 14'h039B
`define RMC_RXT_K1 14'h1207
`define RMC_RXT_K2 14'h2074
`define RMC_RXT_K3 14'h2EE0
`define RMC_RXT_FRAC 5'h08

`endif

// [logic/rmc_pkg.sv]
// types of the modem configuration bank
package rmc_pkg;
	typedef enum logic [0:0] {
		RMC_PH_HEADER = 1'b0,
		RMC_PH_DATA = 1'b1
	} rmc_phase_t;
endpackage

// [logic/rmc_top.sv]
// modem configuration registers behind the serial port, with derived modem settings
`timescale 1ns/1ns
`include "rmc_params.svh"

// Notes on behaviour
// - bit 7 switches error correction with interleaving
// - preamble code 0..7 gives 2..24 bytes
// - spacing is (256+mantissa) shifted by exponent
// - frequency is four times base plus spacing times channel
// - deviation is (8+mantissa) shifted by exponent, zero under msk
// - under msk mantissa sets phase change fraction
// - stop receive without carrier in eight periods
// - timeout code bounds sync search, resets seven
module rmc_top (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic spi_sclk_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_mosi_i,
	output logic spi_miso_o,
	input wire logic msk_mode_i,
	input wire logic [23:0] base_freq_i,
	input wire logic [7:0] channel_index_i,
	input wire logic [15:0] wake_event_period_i,
	input wire logic [1:0] wake_resolution_i,
	input wire logic rx_active_i,
	input wire logic rx_period_tick_i,
	input wire logic carrier_sense_i,
	input wire logic sync_found_i,
	input wire logic preamble_quality_i,
	output logic forward_error_correction_on_o,
	output logic [4:0] preamble_bytes_o,
	output logic [11:0] channel_step_o,
	output logic [26:0] rf_freq_word_o,
	output logic [10:0] freq_deviation_o,
	output logic [2:0] msk_phase_fraction_o,
	output logic rx_timeout_quality_gate_o,
	output logic [21:0] sync_timeout_o,
	output logic sync_timeout_none_o,
	output logic rx_terminate_o
);
	logic [7:0] fec_preamble_spacing_exp_reg;
	logic [7:0] channel_step_mantissa_reg;
	logic [7:0] frequency_deviation_reg;
	logic [7:0] receive_timeout_control_reg;

	// serial port
	rmc_pkg::rmc_phase_t phase;
	logic sclk_q;
	logic [2:0] bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] shift_out;
	logic [5:0] addr;
	logic rd_mode;
	logic burst;

	wire sclk_rise = spi_sclk_i & ~sclk_q & ~spi_cs_n_i;
	wire sclk_fall = ~spi_sclk_i & sclk_q & ~spi_cs_n_i;
	wire [7:0] next_byte = {shift_in[6:0], spi_mosi_i};
	wire byte_done = sclk_rise & (bit_cnt == 3'h7);
	wire hdr_done = byte_done & (phase == rmc_pkg::RMC_PH_HEADER);
	wire data_done = byte_done & (phase == rmc_pkg::RMC_PH_DATA);
	wire [5:0] rd_addr = hdr_done ? next_byte[5:0] : addr + 6'h01;
	wire [5:0] next_addr = burst ? addr + 6'h01 : addr;
	wire wr_en = data_done & ~rd_mode;
	wire sel_fpe = wr_en & (addr == `RMC_ADDR_FEC_PRE_EXP);
	wire sel_mant = wr_en & (addr == `RMC_ADDR_STEP_MANT);
	wire sel_dev = wr_en & (addr == `RMC_ADDR_DEVIATION);
	wire sel_rxt = wr_en & (addr == `RMC_ADDR_RX_TIMEOUT);

	logic [7:0] rd_data;
	always_comb begin
		case (rd_addr)
			`RMC_ADDR_FEC_PRE_EXP: rd_data = fec_preamble_spacing_exp_reg;
			`RMC_ADDR_STEP_MANT: rd_data = channel_step_mantissa_reg;
			`RMC_ADDR_DEVIATION: rd_data = frequency_deviation_reg;
			`RMC_ADDR_RX_TIMEOUT: rd_data = receive_timeout_control_reg;
			default: rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sclk_q <= 1'b0;
			phase <= rmc_pkg::RMC_PH_HEADER;
			bit_cnt <= 3'h0;
			shift_in <= 8'h00;
			shift_out <= 8'h00;
			addr <= 6'h00;
			rd_mode <= 1'b0;
			burst <= 1'b0;
			spi_miso_o <= 1'b0;
		end else begin
			sclk_q <= spi_sclk_i;
			if (spi_cs_n_i) begin
				phase <= rmc_pkg::RMC_PH_HEADER;
				bit_cnt <= 3'h0;
				shift_out <= 8'h00;
			end else begin
				if (sclk_rise) begin
					bit_cnt <= bit_cnt + 3'h1;
					shift_in <= next_byte;
				end
				if (hdr_done) begin
					phase <= rmc_pkg::RMC_PH_DATA;
					rd_mode <= next_byte[7];
					burst <= next_byte[6];
					addr <= next_byte[5:0];
					shift_out <= rd_data;
				end else if (data_done) begin
					addr <= next_addr;
					phase <= burst ? rmc_pkg::RMC_PH_DATA : rmc_pkg::RMC_PH_HEADER;
					shift_out <= rd_data;
				end else if (sclk_fall) begin
					spi_miso_o <= shift_out[7];
					shift_out <= {shift_out[6:0], 1'b0};
				end
			end
		end
	end

	// register file, reserved bits stay zero
	rmc_cfg_reg #(
		.RST_VAL(`RMC_RST_FEC_PRE_EXP),
		.WR_MASK(`RMC_MASK_FEC_PRE_EXP)
	) reg_fpe (
		.clk_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_i(sel_fpe),
		.data_i(next_byte),
		.q_o(fec_preamble_spacing_exp_reg)
	);

	rmc_cfg_reg #(
		.RST_VAL(`RMC_RST_STEP_MANT),
		.WR_MASK(`RMC_MASK_STEP_MANT)
	) reg_mant (
		.clk_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_i(sel_mant),
		.data_i(next_byte),
		.q_o(channel_step_mantissa_reg)
	);

	rmc_cfg_reg #(
		.RST_VAL(`RMC_RST_DEVIATION),
		.WR_MASK(`RMC_MASK_DEVIATION)
	) reg_dev (
		.clk_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_i(sel_dev),
		.data_i(next_byte),
		.q_o(frequency_deviation_reg)
	);

	rmc_cfg_reg #(
		.RST_VAL(`RMC_RST_RX_TIMEOUT),
		.WR_MASK(`RMC_MASK_RX_TIMEOUT)
	) reg_rxt (
		.clk_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.wr_i(sel_rxt),
		.data_i(next_byte),
		.q_o(receive_timeout_control_reg)
	);

	// derived modem settings
	wire [2:0] pre_code = fec_preamble_spacing_exp_reg[`RMC_PRE_HI:`RMC_PRE_LO];
	wire [1:0] spc_e = fec_preamble_spacing_exp_reg[`RMC_SPC_E_HI:`RMC_SPC_E_LO];
	wire [2:0] dev_e = frequency_deviation_reg[`RMC_DEV_E_HI:`RMC_DEV_E_LO];
	wire [2:0] dev_m = frequency_deviation_reg[`RMC_DEV_M_HI:`RMC_DEV_M_LO];
	wire [2:0] rxt_code = receive_timeout_control_reg[`RMC_RXT_HI:`RMC_RXT_LO];
	wire early_stop_on = receive_timeout_control_reg[`RMC_BIT_EARLY_STOP];

	logic [4:0] pre_bytes;
	always_comb begin
		case (pre_code)
			3'h0: pre_bytes = 5'h02;
			3'h1: pre_bytes = 5'h03;
			3'h2: pre_bytes = 5'h04;
			3'h3: pre_bytes = 5'h06;
			3'h4: pre_bytes = 5'h08;
			3'h5: pre_bytes = 5'h0C;
			3'h6: pre_bytes = 5'h10;
			default: pre_bytes = 5'h18;
		endcase
	end

	logic [13:0] rxt_k;
	always_comb begin
		case (wake_resolution_i)
			2'h0: rxt_k = `RMC_RXT_K0;
			2'h1: rxt_k = `RMC_RXT_K1;
			2'h2: rxt_k = `RMC_RXT_K2;
			default: rxt_k = `RMC_RXT_K3;
		endcase
	end

	wire [11:0] step_base = `RMC_STEP_OFFSET + {4'h0, channel_step_mantissa_reg};
	wire [11:0] next_step = step_base << spc_e;
	wire [19:0] channel_index_prod = channel_step_o * channel_index_i;
	wire [26:0] next_freq = {1'b0, base_freq_i, 2'b00} + {7'h00, channel_index_prod};
	wire [3:0] dev_base = `RMC_DEV_OFFSET | {1'b0, dev_m};
	wire [10:0] next_dev = {7'h00, dev_base} << dev_e;
	wire [29:0] rxt_prod = wake_event_period_i * rxt_k;
	wire [29:0] rxt_shift = rxt_prod >> (`RMC_RXT_FRAC + {2'b00, rxt_code});
	wire [21:0] next_timeout = rxt_shift[21:0];
	wire next_fec = fec_preamble_spacing_exp_reg[`RMC_BIT_FEC];
	wire [10:0] next_dev_out = msk_mode_i ? 11'h000 : next_dev;
	wire [2:0] next_frac = msk_mode_i ? dev_m : 3'h0;
	wire next_gate = receive_timeout_control_reg[`RMC_BIT_QUAL_GATE];
	wire next_none = (rxt_code == `RMC_RXT_UNLIMITED);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			forward_error_correction_on_o <= 1'b0;
			preamble_bytes_o <= 5'h00;
			channel_step_o <= 12'h000;
			rf_freq_word_o <= 27'h0000000;
			freq_deviation_o <= 11'h000;
			msk_phase_fraction_o <= 3'h0;
			rx_timeout_quality_gate_o <= 1'b0;
			sync_timeout_o <= 22'h000000;
			sync_timeout_none_o <= 1'b0;
		end else begin
			forward_error_correction_on_o <= next_fec;
			preamble_bytes_o <= pre_bytes;
			channel_step_o <= next_step;
			rf_freq_word_o <= next_freq;
			freq_deviation_o <= next_dev_out;
			msk_phase_fraction_o <= next_frac;
			rx_timeout_quality_gate_o <= next_gate;
			sync_timeout_o <= next_timeout;
			sync_timeout_none_o <= next_none;
		end
	end

	// receive supervision
	logic [3:0] period_cnt;
	logic cs_seen;
	logic [21:0] sync_cnt;
	wire sync_ok = sync_found_i | (rx_timeout_quality_gate_o & preamble_quality_i);
	wire early_expire = early_stop_on & ~cs_seen & ~carrier_sense_i & rx_period_tick_i
		& (period_cnt == `RMC_EARLY_PERIODS - 4'h1);
	wire [21:0] sync_cnt_inc = sync_cnt + 22'h000001;
	wire period_full = (period_cnt == `RMC_EARLY_PERIODS);
	wire sync_expire = ~sync_timeout_none_o & ~sync_ok & rx_period_tick_i
		& (sync_cnt_inc >= sync_timeout_o);
	// one pulse per expiry even if the next tick follows at once
	wire next_terminate = rx_active_i & ~rx_terminate_o & (early_expire | sync_expire);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			period_cnt <= 4'h0;
			cs_seen <= 1'b0;
			sync_cnt <= 22'h000000;
			rx_terminate_o <= 1'b0;
		end else begin
			rx_terminate_o <= next_terminate;
			if (!rx_active_i || rx_terminate_o) begin
				period_cnt <= 4'h0;
				cs_seen <= 1'b0;
				sync_cnt <= 22'h000000;
			end else begin
				if (carrier_sense_i)
					cs_seen <= 1'b1;
				if (rx_period_tick_i && !period_full)
					period_cnt <= period_cnt + 4'h1;
				if (rx_period_tick_i && !sync_ok)
					sync_cnt <= sync_cnt_inc;
			end
		end
	end
endmodule

// one configuration register, reserved bits forced to zero on write
module rmc_cfg_reg #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] WR_MASK = 8'hFF
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic wr_i,
	input wire logic [7:0] data_i,
	output logic [7:0] q_o
);
	wire [7:0] next_q = data_i & WR_MASK;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q_o <= RST_VAL;
		end else if (wr_i) begin
			q_o <= next_q;
		end
	end
endmodule

// [test/rmc_top_chk.sv]
// port assertions for the modem configuration bank
`timescale 1ns/1ns
module rmc_top_chk (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic msk_mode_i,
	input wire logic [23:0] base_freq_i,
	input wire logic [7:0] channel_index_i,
	input wire logic rx_active_i,
	input wire logic rx_period_tick_i,
	input wire logic [4:0] preamble_bytes_o,
	input wire logic [11:0] channel_step_o,
	input wire logic [26:0] rf_freq_word_o,
	input wire logic [10:0] freq_deviation_o,
	input wire logic [2:0] msk_phase_fraction_o,
	input wire logic rx_terminate_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	pre_table_a: assert property ($past(rst_n_i, 2) |-> preamble_bytes_o inside
		{2, 3, 4, 6, 8, 12, 16, 24}) else $error("bad preamble");
	step_range_a: assert property ($past(rst_n_i, 2) |-> channel_step_o >= 12'h100
		&& channel_step_o <= 12'hFF8) else $error("bad step");
	freq_sum_a: assert property ($stable(base_freq_i) && $stable(channel_index_i)
		&& $stable(channel_step_o) && $past(rst_n_i, 2) |=> rf_freq_word_o == 27'(
		$past(base_freq_i) * 4 + $past(channel_step_o) * $past(channel_index_i)))
		else $error("bad freq");
	dev_msk_a: assert property ($past(rst_n_i) && msk_mode_i |=> freq_deviation_o == 11'h000)
		else $error("bad msk deviation");
	fsk_form_a: assert property ($past(rst_n_i) && !msk_mode_i |=> freq_deviation_o >= 11'h008
		&& msk_phase_fraction_o == 3'h0) else $error("bad fsk deviation");
	term_pulse_a: assert property (rx_terminate_o |=> !rx_terminate_o) else $error("long stop");
	term_cause_a: assert property (rx_terminate_o |-> $past(rx_period_tick_i)
		|| $past(rx_period_tick_i, 2)) else $error("stop without tick");
	term_idle_a: assert property (!rx_active_i ##1 !rx_active_i |=> !rx_terminate_o)
		else $error("stop while idle");
endmodule
bind rmc_top rmc_top_chk chk_i (.*);

// [test/rmc_host.sv]
// spi host model, mode 0, msb first, one header and one data byte per select
`timescale 1ns/1ns
module rmc_host (
	input wire logic clk_i,
	input wire logic miso_i,
	output logic sclk_o = 1'b0,
	output logic cs_n_o = 1'b1,
	output logic mosi_o = 1'b0
);
	task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
		cs_n_o <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			mosi_o <= w[i];
			repeat (4) @(posedge clk_i);
			rd = {rd[6:0], miso_i};
			sclk_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			sclk_o <= 1'b0;
		end
		repeat (4) @(posedge clk_i);
		cs_n_o <= 1'b1;
		// released line must not keep its last level
		mosi_o <= ~mosi_o;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

// [test/tb.sv]
// self-checking bench for the modem configuration bank
`timescale 1ns/1ns
module tb;
	logic clk_sys_i = 1'b0, rst_n_i = 1'b0, msk_mode_i = 1'b0, rx_active_i = 1'b0;
	logic rx_period_tick_i = 1'b0, carrier_sense_i = 1'b0, sync_found_i = 1'b0;
	logic preamble_quality_i = 1'b0;
	logic [23:0] base_freq_i = 24'h10A762;
	logic [7:0] channel_index_i = 8'h05;
	logic [15:0] wake_event_period_i = 16'h0002;
	logic [1:0] wake_resolution_i = 2'h0;
	logic spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, forward_error_correction_on_o;
	logic rx_timeout_quality_gate_o, sync_timeout_none_o, rx_terminate_o;
	logic [4:0] preamble_bytes_o;
	logic [11:0] channel_step_o;
	logic [26:0] rf_freq_word_o;
	logic [10:0] freq_deviation_o;
	logic [2:0] msk_phase_fraction_o;
	logic [21:0] sync_timeout_o;
	logic [7:0] rdat;
	int err_total = 0;
	int samples_checked = 0;
	rmc_top uut (.*);
	rmc_host host (.clk_i(clk_sys_i), .miso_i(spi_miso_o), .sclk_o(spi_sclk_i),
		.cs_n_o(spi_cs_n_i), .mosi_o(spi_mosi_i));
	always #25 clk_sys_i = ~clk_sys_i;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host.xfer({a | 8'h80, 8'h00}, rdat);
		chk(rdat, e);
	endtask
	// ticks spaced four cycles, carrier only at the first one
	task automatic ticks(input int n, input logic exp);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			rx_period_tick_i <= 1'b1;
			@(posedge clk_sys_i);
			rx_period_tick_i <= 1'b0;
			carrier_sense_i <= 1'b0;
			repeat (3) begin
				@(posedge clk_sys_i);
				seen = seen | (rx_terminate_o === 1'b1);
			end
		end
		chk(seen, exp);
	endtask
	task automatic rx_restart();
		rx_active_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rx_active_i <= 1'b1;
	endtask
	task automatic t_reset();
		rd_chk(8'h13, 8'h22);
		rd_chk(8'h14, 8'hF8);
		rd_chk(8'h15, 8'h47);
		rd_chk(8'h16, 8'h07);
		rd_chk(8'h2A, 8'h00);
		$display("reset values done");
	endtask
	task automatic t_modem();
		logic [2:0] c;
		int bytes[8] = '{2, 3, 4, 6, 8, 12, 16, 24};
		for (int i = 0; i < 8; i++) begin
			c = 3'(i);
			host.xfer({8'h13, c[0], c, 2'b00, c[1:0]}, rdat);
			chk(preamble_bytes_o, bytes[i]);
			chk(forward_error_correction_on_o, c[0]);
			chk(channel_step_o, 32'h1F8 << c[1:0]);
		end
		host.xfer({8'h14, 8'hAB}, rdat);
		for (int k = 0; k < 2; k++) begin
			channel_index_i <= k ? 8'hFF : 8'h05;
			repeat (3) @(posedge clk_sys_i);
			chk(rf_freq_word_o, base_freq_i * 4 + 32'hD58 * channel_index_i);
		end
		$display("modem spacing done");
	endtask
	task automatic t_dev();
		host.xfer({8'h15, 8'hDB}, rdat);
		rd_chk(8'h15, 8'h53);
		for (int m = 0; m < 2; m++) begin
			msk_mode_i <= 1'(m);
			repeat (3) @(posedge clk_sys_i);
			chk(freq_deviation_o, m ? 0 : 11 << 5);
			chk(msk_phase_fraction_o, m ? 3 : 0);
		end
		msk_mode_i <= 1'b0;
		$display("deviation done");
	endtask
	task automatic t_rx();
		int ktab[4] = '{923, 4615, 8308, 12000};
		host.xfer({8'h16, 8'h17}, rdat);
		chk(sync_timeout_none_o, 1);
		rx_restart();
		ticks(7, 1'b0);
		ticks(1, 1'b1);
		rx_restart();
		carrier_sense_i <= 1'b1;
		ticks(9, 1'b0);
		host.xfer({8'h16, 8'h08}, rdat);
		chk(rx_timeout_quality_gate_o, 1);
		for (int r = 3; r >= 0; r--) begin
			wake_resolution_i <= 2'(r);
			repeat (3) @(posedge clk_sys_i);
			chk(sync_timeout_o, ktab[r] * 2 >> 8);
		end
		rx_restart();
		ticks(6, 1'b0);
		ticks(1, 1'b1);
		rx_restart();
		preamble_quality_i <= 1'b1;
		ticks(9, 1'b0);
		rx_restart();
		preamble_quality_i <= 1'b0;
		sync_found_i <= 1'b1;
		ticks(9, 1'b0);
		sync_found_i <= 1'b0;
		rx_active_i <= 1'b0;
		$display("receive supervision done");
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		t_reset();
		t_modem();
		t_dev();
		t_rx();
		finish_test();
	end
endmodule
